//--- hdl/blk_soft_reset_clock_gate.sv
/*
  block soft-reset and clock-gate control: two 16-bit registers written
  and read through the serial port's internal register strobes, driving
  per-block reset holds and per-block clock gates.
  assumes the serial port front end delivers decoded one-cycle strobes on
  clock, and that sys_rst is asserted only at power-up.
*/
// Notes on behaviour
// - bias calibration held while its bit set
// - time converter held while bit 7 set
// - digital loop held while bit 6 set
// - inverted input activity monitor held, bit 5
// - true input activity monitor held, bit 4
// - crystal signal loss monitor held, bit 3
// - inverted input signal loss held, bit 2
// - true input signal loss held, bit 1
// - fuse memory logic held while bit 0
// - all control bits reset to zero
// - gate bit 5 stops inverted activity clock
// - gate bit 4 stops true activity clock
// - gate bits 3..1 stop loss monitor clocks
// - bit 11 gates all other digital clocks
// - bit 11 also locks out register access
// - global gate cleared only by power cycle
`timescale 1ns/1ps
module blk_soft_reset_clock_gate
  import blk_ctrl_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // register strobes from the serial port front end
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  output logic      [DATA_W-1:0]    reg_rdata,
  output logic                      reg_rd_valid,
  output logic                      reg_access_refused,
  output logic                      reg_bus_locked,
  // reset holds to the controlled blocks, active high
  output logic                      bias_calib_reset_hold,
  output logic                      time_converter_reset_hold,
  output logic                      digital_loop_reset_hold,
  output logic                      inv_input_activity_reset_hold,
  output logic                      true_input_activity_reset_hold,
  output logic                      crystal_signal_loss_reset_hold,
  output logic                      inv_input_signal_loss_reset_hold,
  output logic                      true_input_signal_loss_reset_hold,
  output logic                      fuse_memory_reset_hold,
  // gate levels as stored
  output logic                      inv_input_activity_gate,
  output logic                      true_input_activity_gate,
  output logic                      crystal_signal_loss_gate,
  output logic                      inv_input_signal_loss_gate,
  output logic                      true_input_signal_loss_gate,
  output logic                      global_digital_gate,
  // gated clocks to the controlled blocks
  output wire logic                 inv_activity_clk,
  output wire logic                 true_activity_clk,
  output wire logic                 crystal_loss_clk,
  output wire logic                 inv_loss_clk,
  output wire logic                 true_loss_clk,
  output wire logic                 digital_core_clk
);

  logic [DATA_W-1:0]       soft_reset_reg;
  logic [DATA_W-1:0]       soft_reset_next;
  logic [DATA_W-1:0]       clock_gate_reg;
  logic [DATA_W-1:0]       clock_gate_next;
  logic                    global_gate_reg;
  logic                    access_ok;
  logic                    wr_soft_reset;
  logic                    wr_clock_gate;
  logic [DATA_W-1:0]       read_value;
  logic [GATED_CLOCKS-1:0] stop_vec;
  logic [GATED_CLOCKS-1:0] clk_out_vec;

  // masked write merge shared by both registers
  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] wdata,
    input logic [DATA_W-1:0] rw_mask
  );
    merge_write = wdata & rw_mask;
  endfunction

  // address match used by write and read decode
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx
  );
    hit = (addr == idx);
  endfunction

  // the register bus clock is gated with the rest of the digital logic,
  // so once the global gate is up no strobe is honoured
  assign access_ok     = ~global_gate_reg;
  assign wr_soft_reset = reg_wr_en & access_ok & hit(reg_addr, SOFT_RESET_IDX);
  assign wr_clock_gate = reg_wr_en & access_ok & hit(reg_addr, CLOCK_GATE_IDX);

  // next values; read-only reserved bits are masked to zero
  always_comb begin
    soft_reset_next = soft_reset_reg;
    if (wr_soft_reset) begin
      soft_reset_next = merge_write(reg_wdata, SOFT_RESET_RW_MASK);
    end
  end

  always_comb begin
    clock_gate_next = clock_gate_reg;
    if (wr_clock_gate) begin
      clock_gate_next = merge_write(reg_wdata, CLOCK_GATE_RW_MASK);
    end
    // a write can set the global gate but never clear it
    if (global_gate_reg) begin
      clock_gate_next[GLOBAL_DIGITAL_GATE_BIT] = 1'b1;
    end
  end

  // soft reset register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      soft_reset_reg <= SOFT_RESET_RESET;
    end else begin
      soft_reset_reg <= soft_reset_next;
    end
  end

  // clock gate register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clock_gate_reg <= CLOCK_GATE_RESET;
    end else begin
      clock_gate_reg <= clock_gate_next;
    end
  end

  // sticky global gate; only the power-up reset releases it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      global_gate_reg <= 1'b0;
    end else if (wr_clock_gate && reg_wdata[GLOBAL_DIGITAL_GATE_BIT]) begin
      global_gate_reg <= 1'b1;
    end else begin
      global_gate_reg <= global_gate_reg;
    end
  end

  // read mux
  always_comb begin
    read_value = '0;
    if (hit(reg_addr, SOFT_RESET_IDX)) begin
      read_value = soft_reset_reg;
    end else if (hit(reg_addr, CLOCK_GATE_IDX)) begin
      read_value = clock_gate_reg;
    end
  end

  // read data answers one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd_en && access_ok) begin
      reg_rdata <= read_value;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en & access_ok;
    end
  end

  // strobes that arrive after lock-out are dropped and flagged
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_access_refused <= 1'b0;
    end else begin
      reg_access_refused <= (reg_wr_en | reg_rd_en) & ~access_ok;
    end
  end

  assign reg_bus_locked = global_gate_reg;

  // each hold leaves from its own flop, so a long reset line to a far
  // block carries no decode logic; it mirrors the stored bit exactly
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bias_calib_reset_hold <= SOFT_RESET_RESET[BIAS_CALIB_RST_BIT];
    end else begin
      bias_calib_reset_hold <= soft_reset_next[BIAS_CALIB_RST_BIT];
    end
  end

  // time converter hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_converter_reset_hold <= SOFT_RESET_RESET[TIME_CONVERTER_RST_BIT];
    end else begin
      time_converter_reset_hold <= soft_reset_next[TIME_CONVERTER_RST_BIT];
    end
  end

  // digital loop hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      digital_loop_reset_hold <= SOFT_RESET_RESET[DIGITAL_LOOP_RST_BIT];
    end else begin
      digital_loop_reset_hold <= soft_reset_next[DIGITAL_LOOP_RST_BIT];
    end
  end

  // inverted input activity monitor hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inv_input_activity_reset_hold <= SOFT_RESET_RESET[INV_ACTIVITY_RST_BIT];
    end else begin
      inv_input_activity_reset_hold <= soft_reset_next[INV_ACTIVITY_RST_BIT];
    end
  end

  // true input activity monitor hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      true_input_activity_reset_hold <= SOFT_RESET_RESET[TRUE_ACTIVITY_RST_BIT];
    end else begin
      true_input_activity_reset_hold <= soft_reset_next[TRUE_ACTIVITY_RST_BIT];
    end
  end

  // crystal signal loss monitor hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crystal_signal_loss_reset_hold <= SOFT_RESET_RESET[CRYSTAL_LOSS_RST_BIT];
    end else begin
      crystal_signal_loss_reset_hold <= soft_reset_next[CRYSTAL_LOSS_RST_BIT];
    end
  end

  // inverted input signal loss monitor hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inv_input_signal_loss_reset_hold <= SOFT_RESET_RESET[INV_LOSS_RST_BIT];
    end else begin
      inv_input_signal_loss_reset_hold <= soft_reset_next[INV_LOSS_RST_BIT];
    end
  end

  // true input signal loss monitor hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      true_input_signal_loss_reset_hold <= SOFT_RESET_RESET[TRUE_LOSS_RST_BIT];
    end else begin
      true_input_signal_loss_reset_hold <= soft_reset_next[TRUE_LOSS_RST_BIT];
    end
  end

  // fuse memory hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fuse_memory_reset_hold <= SOFT_RESET_RESET[FUSE_MEMORY_RST_BIT];
    end else begin
      fuse_memory_reset_hold <= soft_reset_next[FUSE_MEMORY_RST_BIT];
    end
  end

  // gate level flags, also one flop each
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inv_input_activity_gate <= CLOCK_GATE_RESET[INV_ACTIVITY_GATE_BIT];
    end else begin
      inv_input_activity_gate <= clock_gate_next[INV_ACTIVITY_GATE_BIT];
    end
  end

  // true input activity gate flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      true_input_activity_gate <= CLOCK_GATE_RESET[TRUE_ACTIVITY_GATE_BIT];
    end else begin
      true_input_activity_gate <= clock_gate_next[TRUE_ACTIVITY_GATE_BIT];
    end
  end

  // crystal signal loss gate flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crystal_signal_loss_gate <= CLOCK_GATE_RESET[CRYSTAL_LOSS_GATE_BIT];
    end else begin
      crystal_signal_loss_gate <= clock_gate_next[CRYSTAL_LOSS_GATE_BIT];
    end
  end

  // inverted input signal loss gate flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inv_input_signal_loss_gate <= CLOCK_GATE_RESET[INV_LOSS_GATE_BIT];
    end else begin
      inv_input_signal_loss_gate <= clock_gate_next[INV_LOSS_GATE_BIT];
    end
  end

  // true input signal loss gate flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      true_input_signal_loss_gate <= CLOCK_GATE_RESET[TRUE_LOSS_GATE_BIT];
    end else begin
      true_input_signal_loss_gate <= clock_gate_next[TRUE_LOSS_GATE_BIT];
    end
  end

  assign global_digital_gate = global_gate_reg;

  // stop requests per gated domain; the monitors keep their own gates
  // and are not stopped by the global gate, which covers only the rest
  assign stop_vec[0] = clock_gate_reg[INV_ACTIVITY_GATE_BIT];
  assign stop_vec[1] = clock_gate_reg[TRUE_ACTIVITY_GATE_BIT];
  assign stop_vec[2] = clock_gate_reg[CRYSTAL_LOSS_GATE_BIT];
  assign stop_vec[3] = clock_gate_reg[INV_LOSS_GATE_BIT];
  assign stop_vec[4] = clock_gate_reg[TRUE_LOSS_GATE_BIT];
  assign stop_vec[5] = global_gate_reg;

  // gate cells; the running flag is not needed here
  for (genvar g = 0; g < GATED_CLOCKS; g++) begin : gate_cells
    clock_stop_cell clock_stop_cell_inst (
      .clk_src     (clock),
      .stop_req    (stop_vec[g]),
      .clk_gated   (clk_out_vec[g]),
      .clk_running ()
    );
  end

  assign inv_activity_clk  = clk_out_vec[0];
  assign true_activity_clk = clk_out_vec[1];
  assign crystal_loss_clk  = clk_out_vec[2];
  assign inv_loss_clk      = clk_out_vec[3];
  assign true_loss_clk     = clk_out_vec[4];
  assign digital_core_clk  = clk_out_vec[5];

endmodule

//--- hdl/blk_ctrl_pkg.sv
/*
  constants for the block soft-reset and clock-gate control registers:
  register indices, field positions, writable masks and reset values.
  assumes an 8-bit register index and 16-bit register words on the
  serial port's internal register strobe interface.
*/
package blk_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // register indices on the serial port's internal register bus
  localparam logic [7:0] SOFT_RESET_IDX = 8'h00;
  localparam logic [7:0] CLOCK_GATE_IDX = 8'h01;

  // soft reset register fields
  localparam int unsigned FUSE_MEMORY_RST_BIT     = 0;
  localparam int unsigned TRUE_LOSS_RST_BIT       = 1;
  localparam int unsigned INV_LOSS_RST_BIT        = 2;
  localparam int unsigned CRYSTAL_LOSS_RST_BIT    = 3;
  localparam int unsigned TRUE_ACTIVITY_RST_BIT   = 4;
  localparam int unsigned INV_ACTIVITY_RST_BIT    = 5;
  localparam int unsigned DIGITAL_LOOP_RST_BIT    = 6;
  localparam int unsigned TIME_CONVERTER_RST_BIT  = 7;
  localparam int unsigned BIAS_CALIB_RST_BIT      = 8;

  // clock gate register fields
  localparam int unsigned TRUE_LOSS_GATE_BIT      = 1;
  localparam int unsigned INV_LOSS_GATE_BIT       = 2;
  localparam int unsigned CRYSTAL_LOSS_GATE_BIT   = 3;
  localparam int unsigned TRUE_ACTIVITY_GATE_BIT  = 4;
  localparam int unsigned INV_ACTIVITY_GATE_BIT   = 5;
  localparam int unsigned GLOBAL_DIGITAL_GATE_BIT = 11;

  // bits that store writes; all other bits read as zero
  localparam logic [15:0] SOFT_RESET_RW_MASK = 16'h09ff;
  localparam logic [15:0] CLOCK_GATE_RW_MASK = 16'h097f;

  localparam logic [15:0] SOFT_RESET_RESET = 16'h0000;
  localparam logic [15:0] CLOCK_GATE_RESET = 16'h0000;

  // number of separately gated clock domains (five monitors and the rest)
  localparam int unsigned GATED_CLOCKS = 6;

endpackage

//--- hdl/clock_stop_cell.sv
/*
  glitch-free clock gate cell: a low-transparent latch holds the enable
  so the gated clock only stops or restarts while the source clock is low.
  assumes stop_req is synchronous to clk_src.
*/
`timescale 1ns/1ps
module clock_stop_cell (
  input  wire logic clk_src,
  input  wire logic stop_req,
  output wire logic clk_gated,
  output wire logic clk_running
);

  logic enable_latch;

  // latch closes on the high phase so a change mid-pulse cannot chop it
  always_latch begin
    if (!clk_src) begin
      enable_latch = ~stop_req;
    end
  end

  assign clk_gated   = clk_src & enable_latch;
  assign clk_running = enable_latch;

endmodule

//--- dv/blk_ctrl_monitor.sv
/*
  checker for the soft-reset and clock-gate control block.
  assumes it is bound to blk_soft_reset_clock_gate and sees its ports only.
*/
`timescale 1ns/1ps
module blk_ctrl_monitor
  import blk_ctrl_pkg::*;
(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              reg_wr_en,
  input wire logic              reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_rd_valid,
  input wire logic              reg_access_refused,
  input wire logic              reg_bus_locked,
  input wire logic              bias_calib_reset_hold,
  input wire logic              digital_loop_reset_hold,
  input wire logic              fuse_memory_reset_hold,
  input wire logic              inv_input_activity_gate,
  input wire logic              global_digital_gate
);
  default clocking cb @(posedge clock); endclocking
  sequence s_sr_wr;
    reg_wr_en && !reg_bus_locked && reg_addr == SOFT_RESET_IDX;
  endsequence
  sequence s_cg_wr;
    reg_wr_en && !reg_bus_locked && reg_addr == CLOCK_GATE_IDX;
  endsequence
  sequence s_lock_wr;
    s_cg_wr ##0 reg_wdata[GLOBAL_DIGITAL_GATE_BIT];
  endsequence
  // no disable here: the reset edge itself is what is checked
  AST_RESET_CLEAR: assert property (
    sys_rst |=> !reg_bus_locked && !fuse_memory_reset_hold && !global_digital_gate && !reg_rd_valid)
    else $error("state not cleared by reset");
  AST_RD_ANSWER: assert property (
    disable iff (sys_rst) reg_rd_en && !reg_bus_locked |=> reg_rd_valid && !reg_access_refused)
    else $error("accepted read not answered next cycle");
  AST_REFUSE: assert property (
    disable iff (sys_rst) (reg_wr_en || reg_rd_en) && reg_bus_locked
    |=> reg_access_refused && !reg_rd_valid)
    else $error("strobe while locked not refused");
  AST_LOCK_SET: assert property (
    disable iff (sys_rst) s_lock_wr |=> reg_bus_locked && global_digital_gate)
    else $error("global gate write did not lock");
  AST_LOCK_HOLD: assert property (
    disable iff (sys_rst) reg_bus_locked |=> reg_bus_locked [*3])
    else $error("lock released without reset");
  AST_BIAS_HOLD: assert property (
    disable iff (sys_rst) s_sr_wr |=> bias_calib_reset_hold == $past(reg_wdata[8]))
    else $error("bias hold does not follow bit 8");
  AST_LOOP_HOLD: assert property (
    disable iff (sys_rst) s_sr_wr |=> digital_loop_reset_hold == $past(reg_wdata[6]))
    else $error("loop hold does not follow bit 6");
  AST_INV_GATE: assert property (
    disable iff (sys_rst) s_cg_wr |=> inv_input_activity_gate == $past(reg_wdata[5]))
    else $error("activity gate does not follow bit 5");
  AST_RO_ZERO: assert property (
    disable iff (sys_rst) reg_rd_valid |-> (reg_rdata & 16'hf600) == 16'h0000)
    else $error("read-only bits not zero");
endmodule

bind blk_soft_reset_clock_gate blk_ctrl_monitor blk_ctrl_monitor_inst (.clock, .sys_rst,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
  .reg_access_refused, .reg_bus_locked, .bias_calib_reset_hold, .digital_loop_reset_hold,
  .fuse_memory_reset_hold, .inv_input_activity_gate, .global_digital_gate);

//--- dv/blk_soft_reset_clock_gate_bench.sv
/*
  self-checking bench for the soft-reset and clock-gate control block.
  assumes the design and its bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module blk_soft_reset_clock_gate_bench
  import blk_ctrl_pkg::*;
;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        reg_rd_valid;
  logic        refused;
  logic        locked;
  logic [8:0]  holds;
  logic [5:0]  gates;
  logic        inv_clk;
  logic        core_clk;
  logic [3:0]  mon_clk;
  int          n_mon = 0;
  logic        lk = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  int          seed = 24;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_refused = 0;
  int          n_inv = 0;
  int          n_core = 0;
  int          cycles = 0;

  blk_soft_reset_clock_gate blk_soft_reset_clock_gate_inst (.clock, .sys_rst, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .reg_access_refused(refused), .reg_bus_locked(locked),
    .bias_calib_reset_hold(holds[8]), .time_converter_reset_hold(holds[7]),
    .digital_loop_reset_hold(holds[6]), .inv_input_activity_reset_hold(holds[5]),
    .true_input_activity_reset_hold(holds[4]), .crystal_signal_loss_reset_hold(holds[3]),
    .inv_input_signal_loss_reset_hold(holds[2]), .true_input_signal_loss_reset_hold(holds[1]),
    .fuse_memory_reset_hold(holds[0]), .inv_input_activity_gate(gates[5]),
    .true_input_activity_gate(gates[4]), .crystal_signal_loss_gate(gates[3]),
    .inv_input_signal_loss_gate(gates[2]), .true_input_signal_loss_gate(gates[1]),
    .global_digital_gate(gates[0]), .inv_activity_clk(inv_clk),
    .true_activity_clk(mon_clk[0]), .crystal_loss_clk(mon_clk[1]), .inv_loss_clk(mon_clk[2]),
    .true_loss_clk(mon_clk[3]), .digital_core_clk(core_clk));

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one idle cycle after each strobe keeps every drive to one assignment per step
  task automatic op(logic w, logic r, logic [7:0] a, logic [15:0] wd, logic [15:0] e);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr = a;
    reg_wdata = wd;
    if (r && !lk) exp_q.push_back(e);
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    @(posedge clock);
    #1;
  endtask

  always @(posedge inv_clk) n_inv <= n_inv + 1;
  always @(posedge core_clk) n_core <= n_core + 1;
  always @(posedge mon_clk[0] or posedge mon_clk[1] or posedge mon_clk[2] or posedge mon_clk[3])
    n_mon <= n_mon + 1;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (refused === 1'b1) n_refused <= n_refused + 1;
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 16'h0001, 16'h0000);
      else chk("rdata", reg_rdata, exp_q.pop_front());
    end
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    op(0, 1, SOFT_RESET_IDX, 0, 16'h0000);
    op(0, 1, CLOCK_GATE_IDX, 0, 16'h0000);
    chk("holds", {7'h00, holds}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      op(1, 0, SOFT_RESET_IDX, d, 0);
      chk("holds", {7'h00, holds}, {7'h00, d[8:0]});
      op(0, 1, SOFT_RESET_IDX, 0, d & SOFT_RESET_RW_MASK);
      d[11] = 1'b0;
      op(1, 0, CLOCK_GATE_IDX, d, 0);
      chk("gates", {10'h000, gates}, {10'h000, d[5:1], 1'b0});
      op(0, 1, CLOCK_GATE_IDX, 0, d & CLOCK_GATE_RW_MASK);
    end
    op(1, 0, 8'h05, 16'hffff, 0);
    op(0, 1, 8'h05, 0, 16'h0000);
    op(0, 1, CLOCK_GATE_IDX, 0, d & CLOCK_GATE_RW_MASK);
    op(1, 0, CLOCK_GATE_IDX, 16'h003e, 0);
    n_inv = 0;
    n_mon = 0;
    repeat (5) @(posedge clock);
    #1;
    chk("inv activity clock edges", 16'(n_inv), 16'h0000);
    chk("monitor clock edges", 16'(n_mon), 16'h0000);
    op(1, 0, CLOCK_GATE_IDX, 16'h0800, 0);
    lk = 1'b1;
    n_core = 0;
    chk("locked", {15'h0000, locked}, 16'h0001);
    chk("global gate", {15'h0000, gates[0]}, 16'h0001);
    op(1, 0, CLOCK_GATE_IDX, 16'h0000, 0);
    op(0, 1, SOFT_RESET_IDX, 0, 0);
    @(posedge clock);
    #1;
    chk("refused", 16'(n_refused), 16'h0002);
    chk("still locked", {15'h0000, locked}, 16'h0001);
    chk("core clock edges", 16'(n_core), 16'h0000);
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    lk = 1'b0;
    op(0, 1, CLOCK_GATE_IDX, 0, 16'h0000);
    @(posedge clock);
    #1;
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
